// ==== src/csmf_pkg.sv ====
// Constants, register map and carrier types for the macrocell fabric.
// Assumes a 32-bit APB master and a 250 MHz system clock.
package csmf_pkg;
   localparam int N_IO = 12;
   localparam int N_HID = 4;
   localparam int N_ST = 16;
   localparam int N_DED = 12;
   localparam int N_PAIR = 6;
   localparam int N_CKP = 3;
   // Synchroniser vector layout: dedicated, io, oe pin, clock pins
   localparam int SY_DED = 0;
   localparam int SY_IO = 12;
   localparam int SY_OE = 24;
   localparam int SY_CK = 25;
   localparam int N_SY = 28;
   // Clock pin indices within the clock group
   localparam int CKP_FIRST = 0;
   localparam int CKP_SECOND = 1;
   localparam int CKP_THIRD = 2;
   // APB byte addresses
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_OE_SEL = 8'h04;
   localparam logic [7:0] A_FB_SEL = 8'h08;
   localparam logic [7:0] A_IO_CLK_SEL = 8'h0C;
   localparam logic [7:0] A_IO_BYPASS = 8'h10;
   localparam logic [7:0] A_OUT_BYPASS = 8'h14;
   localparam logic [7:0] A_ST_CLK_SEL = 8'h18;
   localparam logic [7:0] A_DED_CLK_SEL = 8'h1C;
   localparam logic [7:0] A_DED_BYPASS = 8'h20;
   localparam logic [7:0] A_CLK_SRC = 8'h24;
   localparam logic [7:0] A_PAIR_SEL = 8'h28;
   localparam logic [7:0] A_REG_KIND = 8'h2C;
   localparam logic [7:0] A_STATE = 8'h30;
   localparam logic [7:0] A_IN_STAT = 8'h34;
   // Field positions
   localparam int F_RUN = 0;
   localparam int F_ICK2_SRC = 0;
   localparam int F_ICK1_SRC = 1;
   localparam int F_SCK2_SRC = 2;
   localparam int F_IN_STAT_IO = 16;
   localparam int KIND_W = 2;

   typedef enum logic [1:0] {
      CSMF_D = 2'h0,
      CSMF_T = 2'h1,
      CSMF_JK = 2'h2,
      CSMF_RS = 2'h3
   } csmf_kind_t;

   // Unprogrammed state of every bit is zero
   typedef struct packed {
      logic [N_IO-1:0] oe_source_select;
      logic [N_IO-1:0] feedback_source_select;
      logic [N_IO-1:0] io_input_clock_select;
      logic [N_IO-1:0] io_input_bypass;
      logic [N_IO-1:0] output_register_bypass;
      logic [N_ST-1:0] state_clock_select;
      logic [N_DED-1:0] dedicated_input_clock_select;
      logic [N_DED-1:0] dedicated_input_bypass;
      logic input_clock_two_source;
      logic input_clock_one_source;
      logic state_clock_two_source;
      logic [N_PAIR-1:0] pair_input_select;
      logic [N_ST*KIND_W-1:0] reg_kind;
   } csmf_cfg_t;

   localparam csmf_cfg_t CFG_RESET = '0;
endpackage

// ==== src/csmf_fabric.sv ====
// Macrocell fabric: I/O, hidden and dedicated input cells with APB config.
// Assumes the product-term array sits outside and is combinational.
//
// How it works
// - Each I/O cell takes its output enable from its product term at 0 and from the common enable pin at 1.
// - Feedback select 0 returns the state register to the array, 1 returns the cell's input path.
// - Each I/O input register runs on input clock one at select 0 and input clock two at 1.
// - The I/O input bypass feeds the feedback mux from the input register at 0 and the raw pin at 1.
// - Output bypass 0 drives the pin from the state register, 1 straight from the array.
// - Each of the sixteen state registers runs on state clock one at 0 and state clock two at 1.
// - Each dedicated input register runs on input clock one at 0 and input clock two at 1.
// - Each dedicated input shows its register at bypass 0 and the raw pin at bypass 1.
// - Input clock two comes from the second clock pin at 0 and the third at 1.
// - Input clock one comes from the second clock pin at 0 and the first at 1.
// - State clock two is held low at source 0 and follows the third clock pin at 1.
// - Each cell pair feeds the shared array input from member A at 0 and member B at 1.
// - A synchronous product-term reset and set act on all state registers, reset first.
// - Four pinless hidden state registers exist and any I/O state register can be hidden.
// - Each state register works as a D, T, JK or RS element by its kind field.
//
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
module csmf_fabric
   import csmf_pkg::*;
(
   input wire logic CLK,
   input wire logic RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic [N_CKP-1:0] CLK_PIN_IN,
   input wire logic OE_PIN_IN,
   input wire logic [N_DED-1:0] DED_PIN_IN,
   input wire logic [N_IO-1:0] IO_IN,
   output logic [N_IO-1:0] IO_OUT,
   output logic [N_IO-1:0] IO_OE,
   input wire logic [N_ST-1:0] ARRAY_D,
   input wire logic [N_ST-1:0] ARRAY_K,
   input wire logic [N_IO-1:0] ARRAY_OE,
   input wire logic ARRAY_SET,
   input wire logic ARRAY_RST,
   output logic [N_ST-1:0] ARRAY_FB,
   output logic [N_DED-1:0] ARRAY_DED,
   output logic [N_PAIR-1:0] ARRAY_PAIR
);
   csmf_cfg_t cfg_r;
   logic run_r;
   logic [N_SY-1:0] sy1_r, sy2_r, sy3_r, pin_r;
   logic [N_CKP-1:0] ckp;
   logic ick1, ick2, sck1, sck2;
   logic ick1_q_r, ick2_q_r, sck1_q_r, sck2_q_r;
   logic ick1_rise, ick2_rise, sck1_rise, sck2_rise;
   logic [N_DED-1:0] ded_pin, ded_q_r;
   logic [N_IO-1:0] io_pin, io_q_r, io_path;
   logic oe_pin;
   logic [N_ST-1:0] state_r;
   logic setup, access, wr_ok, addr_ok;
   logic [31:0] rd_nxt;

   // Pins reach the clock domain through three flops; a level counts
   // only once the second and third agree, which rejects one-cycle glitches
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         sy1_r <= '0;
         sy2_r <= '0;
         sy3_r <= '0;
         pin_r <= '0;
      end else begin
         sy1_r <= {CLK_PIN_IN, OE_PIN_IN, IO_IN, DED_PIN_IN};
         sy2_r <= sy1_r;
         sy3_r <= sy2_r;
         pin_r <= (sy2_r & sy3_r) | (pin_r & (sy2_r ^ sy3_r));
      end
   end

   assign ded_pin = pin_r[SY_DED +: N_DED];
   assign io_pin = pin_r[SY_IO +: N_IO];
   assign oe_pin = pin_r[SY_OE];
   assign ckp = pin_r[SY_CK +: N_CKP];

   assign ick1 = cfg_r.input_clock_one_source ? ckp[CKP_FIRST]
                                              : ckp[CKP_SECOND];
   assign ick2 = cfg_r.input_clock_two_source ? ckp[CKP_THIRD]
                                              : ckp[CKP_SECOND];
   assign sck1 = ckp[CKP_FIRST];
   assign sck2 = cfg_r.state_clock_two_source & ckp[CKP_THIRD];

   // Pin clocks become edge strobes; the fabric itself stays on CLK
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         ick1_q_r <= 1'b0;
         ick2_q_r <= 1'b0;
         sck1_q_r <= 1'b0;
         sck2_q_r <= 1'b0;
      end else begin
         ick1_q_r <= ick1;
         ick2_q_r <= ick2;
         sck1_q_r <= sck1;
         sck2_q_r <= sck2;
      end
   end

   assign ick1_rise = run_r & ick1 & ~ick1_q_r;
   assign ick2_rise = run_r & ick2 & ~ick2_q_r;
   assign sck1_rise = run_r & sck1 & ~sck1_q_r;
   assign sck2_rise = run_r & sck2 & ~sck2_q_r;

   genvar g;
   generate
      for (g = 0; g < N_DED; g++) begin : g_ded
         always_ff @(posedge CLK or posedge RST) begin
            if (RST) begin
               ded_q_r[g] <= 1'b0;
            end else if (cfg_r.dedicated_input_clock_select[g] ? ick2_rise
                                                                : ick1_rise) begin
               ded_q_r[g] <= ded_pin[g];
            end
         end
         assign ARRAY_DED[g] = cfg_r.dedicated_input_bypass[g] ? ded_pin[g]
                                                              : ded_q_r[g];
      end

      for (g = 0; g < N_IO; g++) begin : g_io
         always_ff @(posedge CLK or posedge RST) begin
            if (RST) begin
               io_q_r[g] <= 1'b0;
            end else if (cfg_r.io_input_clock_select[g] ? ick2_rise
                                                         : ick1_rise) begin
               io_q_r[g] <= io_pin[g];
            end
         end
         assign io_path[g] = cfg_r.io_input_bypass[g] ? io_pin[g] : io_q_r[g];
         assign ARRAY_FB[g] = cfg_r.feedback_source_select[g] ? io_path[g]
                                                              : state_r[g];
         assign IO_OUT[g] = cfg_r.output_register_bypass[g] ? ARRAY_D[g]
                                                            : state_r[g];
         // at oe source select 0, a low enable term hides the state register from its pin
         assign IO_OE[g] = cfg_r.oe_source_select[g] ? oe_pin : ARRAY_OE[g];
      end

      for (g = 0; g < N_PAIR; g++) begin : g_pair
         assign ARRAY_PAIR[g] = cfg_r.pair_input_select[g] ? io_path[2*g+1]
                                                           : io_path[2*g];
      end

      for (g = 0; g < N_ST; g++) begin : g_st
         csmf_kind_t kind;
         assign kind = csmf_kind_t'(cfg_r.reg_kind[g*KIND_W +: KIND_W]);
         // hidden cells feed back their state only
         if (g >= N_IO) begin : g_hid
            assign ARRAY_FB[g] = state_r[g];
         end
         always_ff @(posedge CLK or posedge RST) begin
            if (RST) begin
               state_r[g] <= 1'b0;
            end else if (cfg_r.state_clock_select[g] ? sck2_rise
                                                     : sck1_rise) begin
               if (ARRAY_RST) begin
                  state_r[g] <= 1'b0;
               end else if (ARRAY_SET) begin
                  state_r[g] <= 1'b1;
               end else begin
                  case (kind)
                     CSMF_D: state_r[g] <= ARRAY_D[g];
                     CSMF_T: state_r[g] <= state_r[g] ^ ARRAY_D[g];
                     CSMF_JK: state_r[g] <= (ARRAY_D[g] & ~state_r[g]) |
                                            (~ARRAY_K[g] & state_r[g]);
                     // Both high on RS is illegal; reset is kept
                     CSMF_RS: state_r[g] <= ~ARRAY_K[g] &
                                            (ARRAY_D[g] | state_r[g]);
                     default: state_r[g] <= state_r[g];
                  endcase
               end
            end
         end
      end
   endgenerate

   // APB slave: zero wait states, read data captured in the setup cycle
   assign setup = PSEL & ~PENABLE;
   assign access = PSEL & PENABLE;
   assign PREADY = 1'b1;

   always_comb begin
      rd_nxt = '0;
      addr_ok = 1'b1;
      case (PADDR)
         A_CTRL: rd_nxt[F_RUN] = run_r;
         A_OE_SEL: rd_nxt[N_IO-1:0] = cfg_r.oe_source_select;
         A_FB_SEL: rd_nxt[N_IO-1:0] = cfg_r.feedback_source_select;
         A_IO_CLK_SEL: rd_nxt[N_IO-1:0] = cfg_r.io_input_clock_select;
         A_IO_BYPASS: rd_nxt[N_IO-1:0] = cfg_r.io_input_bypass;
         A_OUT_BYPASS: rd_nxt[N_IO-1:0] = cfg_r.output_register_bypass;
         A_ST_CLK_SEL: rd_nxt[N_ST-1:0] = cfg_r.state_clock_select;
         A_DED_CLK_SEL: rd_nxt[N_DED-1:0] =
            cfg_r.dedicated_input_clock_select;
         A_DED_BYPASS: rd_nxt[N_DED-1:0] = cfg_r.dedicated_input_bypass;
         A_CLK_SRC: begin
            rd_nxt[F_ICK2_SRC] = cfg_r.input_clock_two_source;
            rd_nxt[F_ICK1_SRC] = cfg_r.input_clock_one_source;
            rd_nxt[F_SCK2_SRC] = cfg_r.state_clock_two_source;
         end
         A_PAIR_SEL: rd_nxt[N_PAIR-1:0] = cfg_r.pair_input_select;
         A_REG_KIND: rd_nxt = cfg_r.reg_kind;
         A_STATE: rd_nxt[N_ST-1:0] = state_r;
         A_IN_STAT: begin
            rd_nxt[N_DED-1:0] = ded_q_r;
            rd_nxt[F_IN_STAT_IO +: N_IO] = io_q_r;
         end
         default: addr_ok = 1'b0;
      endcase
   end

   // config writes refused while the fabric runs
   assign wr_ok = addr_ok & (PADDR == A_CTRL |
                  (~run_r & PADDR != A_STATE & PADDR != A_IN_STAT));
   assign PSLVERR = access & (PWRITE ? ~wr_ok : ~addr_ok);

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         PRDATA <= '0;
      end else if (setup) begin
         PRDATA <= rd_nxt;
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         cfg_r <= CFG_RESET;
         run_r <= 1'b0;
      end else if (access & PWRITE & wr_ok) begin
         case (PADDR)
            A_CTRL: run_r <= PWDATA[F_RUN];
            A_OE_SEL: cfg_r.oe_source_select <= PWDATA[N_IO-1:0];
            A_FB_SEL: cfg_r.feedback_source_select <= PWDATA[N_IO-1:0];
            A_IO_CLK_SEL: cfg_r.io_input_clock_select <= PWDATA[N_IO-1:0];
            A_IO_BYPASS: cfg_r.io_input_bypass <= PWDATA[N_IO-1:0];
            A_OUT_BYPASS: cfg_r.output_register_bypass <= PWDATA[N_IO-1:0];
            A_ST_CLK_SEL: cfg_r.state_clock_select <= PWDATA[N_ST-1:0];
            A_DED_CLK_SEL: cfg_r.dedicated_input_clock_select <=
               PWDATA[N_DED-1:0];
            A_DED_BYPASS: cfg_r.dedicated_input_bypass <= PWDATA[N_DED-1:0];
            A_CLK_SRC: begin
               cfg_r.input_clock_two_source <= PWDATA[F_ICK2_SRC];
               cfg_r.input_clock_one_source <= PWDATA[F_ICK1_SRC];
               cfg_r.state_clock_two_source <= PWDATA[F_SCK2_SRC];
            end
            A_PAIR_SEL: cfg_r.pair_input_select <= PWDATA[N_PAIR-1:0];
            A_REG_KIND: cfg_r.reg_kind <= PWDATA;
            default: run_r <= run_r;
         endcase
      end
   end

   oe_source_a: assert property (@(posedge CLK) disable iff (RST)
      IO_OE[0] == (cfg_r.oe_source_select[0] ? oe_pin : ARRAY_OE[0]))
      else $error("output enable source wrong");
   feedback_mux_a: assert property (@(posedge CLK) disable iff (RST)
      !cfg_r.feedback_source_select[0] |-> ARRAY_FB[0] == state_r[0])
      else $error("feedback not from state register");
   io_clock_a: assert property (@(posedge CLK) disable iff (RST)
      (ick2_rise && cfg_r.io_input_clock_select[0])
      |=> io_q_r[0] == $past(io_pin[0]))
      else $error("io input register missed clock two");
   io_bypass_a: assert property (@(posedge CLK) disable iff (RST)
      (cfg_r.io_input_bypass[0] && cfg_r.feedback_source_select[0])
      |-> ARRAY_FB[0] == io_pin[0])
      else $error("io bypass not taken");
   out_bypass_a: assert property (@(posedge CLK) disable iff (RST)
      cfg_r.output_register_bypass[1] |-> IO_OUT[1] == ARRAY_D[1])
      else $error("output bypass not combinational");
   state_reset_a: assert property (@(posedge CLK) disable iff (RST)
      ((cfg_r.state_clock_select[0] ? sck2_rise : sck1_rise) && ARRAY_RST)
      |=> state_r[0] == 1'b0)
      else $error("sync reset ignored");
   ded_clock_a: assert property (@(posedge CLK) disable iff (RST)
      (ick1_rise && !cfg_r.dedicated_input_clock_select[0])
      |=> ded_q_r[0] == $past(ded_pin[0]))
      else $error("dedicated register missed clock one");
   ded_bypass_a: assert property (@(posedge CLK) disable iff (RST)
      !cfg_r.dedicated_input_bypass[0] |-> ARRAY_DED[0] == ded_q_r[0])
      else $error("dedicated input not registered");
   state_clock_two_ground_a: assert property (@(posedge CLK) disable iff (RST)
      !cfg_r.state_clock_two_source |-> !sck2_rise)
      else $error("state clock two toggled while grounded");
   cfg_static_a: assert property (@(posedge CLK) disable iff (RST)
      run_r ##1 run_r |-> $stable(cfg_r))
      else $error("configuration changed while running");
   st_hold_a: assert property (@(posedge CLK) disable iff (RST)
      !(cfg_r.state_clock_select[0] ? sck2_rise : sck1_rise)
      |=> $stable(state_r[0]))
      else $error("state register moved without its clock");
   pair_select_a: assert property (@(posedge CLK) disable iff (RST)
      cfg_r.pair_input_select[0] |-> ARRAY_PAIR[0] == io_path[1])
      else $error("pair input not from member B");
   ick1_source_a: assert property (@(posedge CLK) disable iff (RST)
      cfg_r.input_clock_one_source |-> ick1 == ckp[CKP_FIRST])
      else $error("input clock one not from first pin");
endmodule

// ==== tb/csmf_fabric_tb.sv ====
// Self-checking bench for the macrocell fabric, driven over APB and pins.
// Assumes pin clocks held high four CLK cycles and low six; APB waits on pready.
`timescale 1ns/1ps
module csmf_fabric_tb
   import csmf_pkg::*;
;
   logic CLK = 1'b0;
   logic RST = 1'b1;
   logic PSEL = 1'b0;
   logic PENABLE = 1'b0;
   logic PWRITE = 1'b0;
   logic [7:0] PADDR = 8'h00;
   logic [31:0] PWDATA = 32'h0;
   logic [31:0] PRDATA;
   logic PREADY;
   logic PSLVERR;
   logic [N_CKP-1:0] CLK_PIN_IN = '0;
   logic OE_PIN_IN = 1'b0;
   logic [N_DED-1:0] DED_PIN_IN = '0;
   logic [N_IO-1:0] IO_IN = '0;
   logic [N_IO-1:0] IO_OUT;
   logic [N_IO-1:0] IO_OE;
   logic [N_ST-1:0] ARRAY_D = '0;
   logic [N_ST-1:0] ARRAY_K = '0;
   logic [N_IO-1:0] ARRAY_OE = '0;
   logic ARRAY_SET = 1'b0;
   logic ARRAY_RST = 1'b0;
   logic [N_ST-1:0] ARRAY_FB;
   logic [N_DED-1:0] ARRAY_DED;
   logic [N_PAIR-1:0] ARRAY_PAIR;
   int n_errors = 0;
   int check_count = 0;
   logic [15:0] q = 16'h0;
   logic [5:0] ep;

   csmf_fabric csmf_fabric_i (.CLK(CLK), .RST(RST), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
      .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .CLK_PIN_IN(CLK_PIN_IN), .OE_PIN_IN(OE_PIN_IN), .DED_PIN_IN(DED_PIN_IN),
      .IO_IN(IO_IN), .IO_OUT(IO_OUT), .IO_OE(IO_OE), .ARRAY_D(ARRAY_D),
      .ARRAY_K(ARRAY_K), .ARRAY_OE(ARRAY_OE), .ARRAY_SET(ARRAY_SET),
      .ARRAY_RST(ARRAY_RST), .ARRAY_FB(ARRAY_FB), .ARRAY_DED(ARRAY_DED),
      .ARRAY_PAIR(ARRAY_PAIR));

   initial begin
      forever #2 CLK = ~CLK;
   end

   task automatic final_report;
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask

   // Request held until pready is sampled high at a rising edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic eerr,
                      input logic [31:0] e);
      @(posedge CLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      // Only the watchdog ends a wait that never sees pready
      do begin
         @(posedge CLK);
      end while (PREADY !== 1'b1);
      chk("pslverr", {31'h0, eerr}, {31'h0, PSLVERR});
      if (!w) begin
         chk("prdata", e, PRDATA);
      end
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 1'b0, 32'h0);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0, 1'b0, e);
   endtask

   task automatic settle;
      repeat (5) @(posedge CLK);
   endtask

   // Pin clock kept high four cycles and low six so the filter passes it
   task automatic pulse(input int p);
      @(posedge CLK);
      CLK_PIN_IN[p] <= 1'b1;
      repeat (4) @(posedge CLK);
      CLK_PIN_IN[p] <= 1'b0;
      repeat (6) @(posedge CLK);
   endtask

   function automatic logic [15:0] nxt(input logic [1:0] kd,
      input logic [15:0] qq, input logic [15:0] d, input logic [15:0] k);
      case (kd)
         2'h0: return d;
         2'h1: return qq ^ d;
         2'h2: return (d & ~qq) | (~k & qq);
         default: return (d & ~k) | (qq & ~d & ~k);
      endcase
   endfunction

   // Cells in mask m see the strobe; the rest must hold
   task automatic step(input int p, input logic [1:0] kd,
      input logic [15:0] m, input logic [15:0] d, input logic [15:0] k,
      input logic s, input logic r);
      logic [15:0] t;
      ARRAY_D <= d;
      ARRAY_K <= k;
      ARRAY_SET <= s;
      ARRAY_RST <= r;
      pulse(p);
      t = r ? 16'h0 : (s ? 16'hFFFF : nxt(kd, q, d, k));
      q = (t & m) | (q & ~m);
      ARRAY_SET <= 1'b0;
      ARRAY_RST <= 1'b0;
      rd(A_STATE, {16'h0, q});
   endtask

   initial begin
      repeat (10) @(posedge CLK);
      RST <= 1'b0;
      for (int a = 0; a <= 'h34; a += 4) begin
         rd(8'(a), 32'h0);
      end
      apb(1'b0, 8'h38, 32'h0, 1'b1, 32'h0);
      apb(1'b1, A_STATE, 32'hFFFF, 1'b1, 32'h0);
      ARRAY_OE <= 12'hA5C;
      OE_PIN_IN <= 1'b1;
      wr(A_OE_SEL, 32'h0F0);
      settle();
      chk("io_oe", 32'hAFC, {20'h0, IO_OE});
      OE_PIN_IN <= 1'b0;
      settle();
      chk("io_oe", 32'hA0C, {20'h0, IO_OE});
      ARRAY_D <= 16'h1234;
      wr(A_OUT_BYPASS, 32'hFFF);
      settle();
      chk("io_out", 32'h234, {20'h0, IO_OUT});
      IO_IN <= 12'h9A6;
      wr(A_FB_SEL, 32'hFFF);
      wr(A_IO_BYPASS, 32'hFFF);
      wr(A_PAIR_SEL, 32'h15);
      settle();
      chk("array_fb", 32'h09A6, {16'h0, ARRAY_FB});
      for (int p = 0; p < N_PAIR; p++) begin
         ep[p] = ((6'h15 >> p) & 6'h01) != 6'h00 ?
            IO_IN[2*p+1] : IO_IN[2*p];
      end
      chk("array_pair", {26'h0, ep}, {26'h0, ARRAY_PAIR});
      DED_PIN_IN <= 12'h3C5;
      wr(A_DED_BYPASS, 32'hFFF);
      settle();
      chk("array_ded", 32'h3C5, {20'h0, ARRAY_DED});
      wr(A_DED_BYPASS, 32'h0);
      wr(A_IO_BYPASS, 32'h0);
      wr(A_FB_SEL, 32'h0);
      wr(A_OUT_BYPASS, 32'h0);
      wr(A_ST_CLK_SEL, 32'hF000);
      wr(A_CTRL, 32'h1);
      apb(1'b1, A_OE_SEL, 32'h0, 1'b1, 32'h0);
      rd(A_OE_SEL, 32'h0F0);
      step(CKP_FIRST, 2'h0, 16'h0FFF, 16'hBEEF, 16'h0, 1'b0, 1'b0);
      rd(A_IN_STAT, 32'h0);
      step(CKP_THIRD, 2'h0, 16'h0, 16'h1111, 16'h0, 1'b0, 1'b0);
      chk("io_out", {20'h0, q[11:0]}, {20'h0, IO_OUT});
      chk("array_fb", {16'h0, q}, {16'h0, ARRAY_FB});
      pulse(CKP_SECOND);
      rd(A_IN_STAT, 32'h09A6_03C5);
      chk("array_ded", 32'h3C5, {20'h0, ARRAY_DED});
      step(CKP_FIRST, 2'h0, 16'h0FFF, 16'h0, 16'h0, 1'b1, 1'b0);
      step(CKP_FIRST, 2'h0, 16'h0FFF, 16'hFFFF, 16'h0, 1'b1, 1'b1);
      wr(A_CTRL, 32'h0);
      wr(A_ST_CLK_SEL, 32'hFFFF);
      wr(A_CLK_SRC, 32'h7);
      wr(A_IO_CLK_SEL, 32'hFFF);
      for (int kd = 1; kd < 4; kd++) begin
         wr(A_CTRL, 32'h0);
         wr(A_REG_KIND, {16{2'(kd)}});
         wr(A_CTRL, 32'h1);
         step(CKP_THIRD, 2'(kd), 16'hFFFF, 16'h0FF0, 16'h3C3C, 1'b0, 1'b0);
         step(CKP_THIRD, 2'(kd), 16'hFFFF, 16'hFF00, 16'h0F0F, 1'b0, 1'b0);
         step(CKP_FIRST, 2'(kd), 16'h0, 16'hFFFF, 16'h0, 1'b0, 1'b0);
      end
      wr(A_CTRL, 32'h0);
      wr(A_DED_CLK_SEL, 32'h0F0);
      wr(A_CTRL, 32'h1);
      DED_PIN_IN <= 12'h5A3;
      IO_IN <= 12'h18E;
      pulse(CKP_FIRST);
      rd(A_IN_STAT, 32'h09A6_05C3);
      pulse(CKP_THIRD);
      rd(A_IN_STAT, 32'h018E_05A3);
      final_report();
   end

   initial begin
      repeat (20000) @(posedge CLK);
      n_errors++;
      final_report();
   end
endmodule
